// ### logic/iwd_defs.vh
`ifndef IWD_DEFS_VH
`define IWD_DEFS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define IWD_OFS_REFRESH   5'h00
`define IWD_OFS_STATUS    5'h04
`define IWD_OFS_CTRL      5'h08
`define IWD_OFS_RSEL      5'h0C
`define IWD_OFS_CSTP      5'h10
`define IWD_OFS_NMIEN     5'h14
`define IWD_OFS_ISTS      5'h18
`define IWD_OFS_IMSK      5'h1C

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define IWD_CR_TIMEOUT_SELECT       1:0
`define IWD_CR_CKS        7:4
`define IWD_CR_WINDOW_END_SELECT       9:8
`define IWD_CR_WINDOW_START_SELECT       13:12
`define IWD_CR_MASK       16'h33F3
`define IWD_CR_RST        16'h3303
`define IWD_SEL_BIT       7
`define IWD_RSEL_RST      1'b0
`define IWD_CSTP_RST      1'b0
`define IWD_NMIEN_RST     1'b0
`define IWD_OPT_STRT      1
`define IWD_OPT_TIMEOUT_SELECT      3:2
`define IWD_OPT_CKS       7:4
`define IWD_OPT_WINDOW_END_SELECT      9:8
`define IWD_OPT_WINDOW_START_SELECT      11:10
`define IWD_OPT_RSTIRQ    14
`define IWD_OPT_LOW_POWER_COUNT_STOP    15
`define IWD_SR_CNT        13:0
`define IWD_SR_RUN        14
`define IWD_IRQ_UF        0
`define IWD_IRQ_RE        1

// ----------------------------------------------------------------------
// Reload values, prescale codes, refresh bytes
// ----------------------------------------------------------------------
`define IWD_RELOAD_0      14'h03FF
`define IWD_RELOAD_1      14'h0FFF
`define IWD_RELOAD_2      14'h1FFF
`define IWD_RELOAD_3      14'h3FFF
`define IWD_CKS_DIV1      4'h0
`define IWD_CKS_DIV16     4'h2
`define IWD_CKS_DIV32     4'h3
`define IWD_CKS_DIV64     4'h4
`define IWD_CKS_DIV128    4'hF
`define IWD_CKS_DIV256    4'h5
`define IWD_REF_FIRST     8'h00
`define IWD_REF_SECOND    8'hFF
`endif

// ### logic/iwd_prescaler.v
`timescale 1ns/1ns
`include "iwd_defs.vh"
module iwd_prescaler (
    // Clock and reset
    input  wire       clk,
    input  wire       rstn,
    // Dedicated count clock and control
    input  wire       dclk,
    input  wire [3:0] prescale_select,
    input  wire       enable,
    input  wire       restart,
    // Prescaled tick
    output reg        tick
);
    reg       dclk_prev_r;
    reg [7:0] div_cnt_r;

    function [7:0] div_last;
        input [3:0] c;
        begin
            case (c)
                `IWD_CKS_DIV16:  div_last = 8'h0F;
                `IWD_CKS_DIV32:  div_last = 8'h1F;
                `IWD_CKS_DIV64:  div_last = 8'h3F;
                `IWD_CKS_DIV128: div_last = 8'h7F;
                `IWD_CKS_DIV256: div_last = 8'hFF;
                default:         div_last = 8'h00;
            endcase
        end
    endfunction

    // The dedicated clock is sampled as a level; each rising edge is one count.
    wire dclk_rise = dclk & ~dclk_prev_r;

    always @(posedge clk) begin
        if (!rstn) begin
            dclk_prev_r <= 1'b0;
            div_cnt_r   <= 8'h00;
            tick        <= 1'b0;
        end else begin
            dclk_prev_r <= dclk;
            tick        <= 1'b0;
            if (restart) begin
                div_cnt_r <= 8'h00;
            end else if (enable && dclk_rise) begin
                if (div_cnt_r >= div_last(prescale_select)) begin
                    div_cnt_r <= 8'h00;
                    tick      <= 1'b1;
                end else begin
                    div_cnt_r <= div_cnt_r + 8'h01;
                end
            end
        end
    end
endmodule // iwd_prescaler

// ### logic/iwd_window.v
`timescale 1ns/1ns
`include "iwd_defs.vh"
module iwd_window (
    // Counter and settings
    input  wire [13:0] cnt,
    input  wire [1:0]  timeout_select,
    input  wire [1:0]  window_start_select,
    input  wire [1:0]  window_end_select,
    // Results
    output reg  [13:0] reload,
    output wire        permitted
);
    function [14:0] bound;
        input [14:0] p;
        input [2:0]  q;
        begin
            case (q)
                3'd0:    bound = 15'h0000;
                3'd1:    bound = p >> 2;
                3'd2:    bound = p >> 1;
                3'd3:    bound = (p >> 1) + (p >> 2);
                default: bound = p;
            endcase
        end
    endfunction

    always @* begin
        case (timeout_select)
            2'b00:   reload = `IWD_RELOAD_0;
            2'b01:   reload = `IWD_RELOAD_1;
            2'b10:   reload = `IWD_RELOAD_2;
            default: reload = `IWD_RELOAD_3;
        endcase
    end

    // Start codes give 25/50/75/100 percent, end codes 75/50/25/0 percent.
    wire [14:0] period = {1'b0, reload} + 15'h0001;
    wire [2:0]  q_s    = {1'b0, window_start_select} + 3'd1;
    wire [2:0]  q_e    = 3'd3 - {1'b0, window_end_select};
    wire [14:0] c15    = {1'b0, cnt};

    assign permitted = (c15 < bound(period, q_s)) &&
                       (c15 >= bound(period, q_e));
endmodule // iwd_window

// ### logic/iwd_top.v
`timescale 1ns/1ns
`include "iwd_defs.vh"
module iwd_top (
    // Clock and reset
    input  wire        clk,
    input  wire        rstn,

    // Avalon-MM slave
    input  wire [4:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,

    // Dedicated count clock and option memory
    input  wire        watchdog_dedicated_clock,
    input  wire [15:0] option_word_zero,

    // Low power state of the chip
    input  wire        low_power_mode,

    // Reset generator and interrupt controller
    output reg         wdt_reset_req,
    output reg         wdt_nmi_req,
    output reg         watchdog_maskable_irq,
    output reg         count_stop_ctrl,

    // Event link
    output reg         evt_underflow,
    output reg         evt_refresh_err,

    // Status interrupt
    output reg         irq
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    reg        init_r;
    reg        start_r;
    reg        auto_mode_r;
    reg [15:0] opt_r;

    reg [15:0] ctl_r;
    reg        rsel_r;
    reg        cstp_r;
    reg        nmien_r;
    reg [1:0]  sts_r;
    reg [1:0]  msk_r;

    reg [3:0]  act_cks_r;
    reg [1:0]  act_timeout_select_r;
    reg [1:0]  act_window_start_select_r;
    reg [1:0]  act_window_end_select_r;

    reg [13:0] cnt_r;
    reg        run_r;
    reg        armed_r;

    reg [31:0] rd_mux;

    wire        tick;
    wire [13:0] reload;
    wire        permitted;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function [15:0] be_merge16;
        input [15:0] old;
        input [15:0] nw;
        input [1:0]  be;
        begin
            be_merge16[7:0]  = be[0] ? nw[7:0]  : old[7:0];
            be_merge16[15:8] = be[1] ? nw[15:8] : old[15:8];
        end
    endfunction

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    // One wait state: the access happens at the edge where
    // waitrequest is seen low, and read data already stands then.
    wire req = avs_read | avs_write;
    wire acc = req & ~avs_waitrequest;
    wire wr  = avs_write & acc;

    wire hit_refresh = (avs_address == `IWD_OFS_REFRESH);
    wire hit_status  = (avs_address == `IWD_OFS_STATUS);
    wire hit_ctrl    = (avs_address == `IWD_OFS_CTRL);
    wire hit_rsel    = (avs_address == `IWD_OFS_RSEL);
    wire hit_cstp    = (avs_address == `IWD_OFS_CSTP);
    wire hit_nmien   = (avs_address == `IWD_OFS_NMIEN);
    wire hit_ists    = (avs_address == `IWD_OFS_ISTS);
    wire hit_imsk    = (avs_address == `IWD_OFS_IMSK);

    wire       b0      = avs_byteenable[0];
    wire [7:0] rr_data = avs_writedata[7:0];
    wire       rr_wr   = wr & hit_refresh & b0;

    // ------------------------------------------------------------------
    // Effective settings
    // ------------------------------------------------------------------
    // Automatic mode follows the option word; register mode the
    // registers, so both paths end in the same selects.
    wire rsel_eff = auto_mode_r ? opt_r[`IWD_OPT_RSTIRQ] : rsel_r;
    wire stop_eff = auto_mode_r ? opt_r[`IWD_OPT_LOW_POWER_COUNT_STOP] : cstp_r;

    wire halt = stop_eff & low_power_mode;

    // ------------------------------------------------------------------
    // Refresh, window and timeout sources
    // ------------------------------------------------------------------
    wire refresh   = rr_wr & armed_r & (rr_data == `IWD_REF_SECOND);
    wire valid_ref = refresh & (~run_r | permitted);
    wire bad_ref   = refresh & run_r & ~permitted;
    wire at_zero   = (cnt_r == 14'h0000);
    wire uf        = run_r & tick & ~halt & at_zero & ~refresh;
    wire timeout   = uf | bad_ref;

    wire [1:0] sts_set = {bad_ref, uf};
    wire [1:0] sts_clr = (wr & hit_ists & b0) ? avs_writedata[1:0] : 2'b00;

    // ------------------------------------------------------------------
    // Prescaler and window
    // ------------------------------------------------------------------
    iwd_prescaler u_presc (
        .clk     (clk),
        .rstn    (rstn),
        .dclk    (watchdog_dedicated_clock),
        .prescale_select     (act_cks_r),
        .enable  (run_r & ~halt),
        .restart (valid_ref | start_r),
        .tick    (tick)
    );

    iwd_window u_win (
        .cnt       (cnt_r),
        .timeout_select      (act_timeout_select_r),
        .window_start_select      (act_window_start_select_r),
        .window_end_select      (act_window_end_select_r),
        .reload    (reload),
        .permitted (permitted)
    );

    // ------------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------------
    always @* begin
        rd_mux = 32'h0000_0000;
        if (hit_status) begin
            rd_mux[`IWD_SR_CNT] = cnt_r;
            rd_mux[`IWD_SR_RUN] = run_r;
        end else if (hit_ctrl) begin
            rd_mux[15:0] = ctl_r;
        end else if (hit_rsel) begin
            rd_mux[`IWD_SEL_BIT] = rsel_r;
        end else if (hit_cstp) begin
            rd_mux[`IWD_SEL_BIT] = cstp_r;
        end else if (hit_nmien) begin
            rd_mux[0] = nmien_r;
        end else if (hit_ists) begin
            rd_mux[1:0] = sts_r;
        end else if (hit_imsk) begin
            rd_mux[1:0] = msk_r;
        end
    end

    // ------------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        if (!rstn) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else if (req && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
            // Read data stand until the next read answer; writes leave them alone.
            if (avs_read) begin
                avs_readdata <= rd_mux;
            end
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        if (!rstn) begin
            ctl_r   <= `IWD_CR_RST;
            rsel_r  <= `IWD_RSEL_RST;
            cstp_r  <= `IWD_CSTP_RST;
            nmien_r <= `IWD_NMIEN_RST;
            msk_r   <= 2'b00;
            armed_r <= 1'b0;
        end else begin
            if (wr && hit_ctrl) begin
                ctl_r <= be_merge16(ctl_r, avs_writedata[15:0],
                                    avs_byteenable[1:0]) & `IWD_CR_MASK;
            end
            if (wr && hit_rsel && b0) begin
                rsel_r <= avs_writedata[`IWD_SEL_BIT];
            end
            if (wr && hit_cstp && b0) begin
                cstp_r <= avs_writedata[`IWD_SEL_BIT];
            end
            if (wr && hit_nmien && b0) begin
                nmien_r <= avs_writedata[0];
            end
            if (wr && hit_imsk && b0) begin
                msk_r <= avs_writedata[1:0];
            end
            // Any refresh-register write with byte 0 enabled, other than the opening byte, breaks the pair.
            if (rr_wr) begin
                armed_r <= (rr_data == `IWD_REF_FIRST);
            end
        end
    end

    // ------------------------------------------------------------------
    // Option capture and active settings
    // ------------------------------------------------------------------
    // The option word is caught one cycle after release, never inside
    // the reset branch, so it is a clean strap sample.
    always @(posedge clk) begin
        if (!rstn) begin
            init_r      <= 1'b1;
            start_r     <= 1'b0;
            auto_mode_r <= 1'b0;
            opt_r       <= 16'h0000;
            act_cks_r   <= ctl_r_rst_cks(1'b0);
            act_timeout_select_r  <= 2'b11;
            act_window_start_select_r  <= 2'b11;
            act_window_end_select_r  <= 2'b11;
        end else begin
            init_r  <= 1'b0;
            start_r <= 1'b0;
            if (init_r) begin
                opt_r       <= option_word_zero;
                auto_mode_r <= ~option_word_zero[`IWD_OPT_STRT];
                if (!option_word_zero[`IWD_OPT_STRT]) begin
                    act_cks_r  <= option_word_zero[`IWD_OPT_CKS];
                    act_timeout_select_r <= option_word_zero[`IWD_OPT_TIMEOUT_SELECT];
                    act_window_start_select_r <= option_word_zero[`IWD_OPT_WINDOW_START_SELECT];
                    act_window_end_select_r <= option_word_zero[`IWD_OPT_WINDOW_END_SELECT];
                    start_r    <= 1'b1;
                end
            end else if (valid_ref && !auto_mode_r) begin
                act_cks_r  <= ctl_r[`IWD_CR_CKS];
                act_timeout_select_r <= ctl_r[`IWD_CR_TIMEOUT_SELECT];
                act_window_start_select_r <= ctl_r[`IWD_CR_WINDOW_START_SELECT];
                act_window_end_select_r <= ctl_r[`IWD_CR_WINDOW_END_SELECT];
            end
        end
    end

    function [3:0] ctl_r_rst_cks;
        input dummy;
        reg [15:0] v;
        begin
            v             = `IWD_CR_RST;
            ctl_r_rst_cks = v[`IWD_CR_CKS];
        end
    endfunction

    // ------------------------------------------------------------------
    // Down-counter
    // ------------------------------------------------------------------
    // The reload of a register-mode refresh uses the previous timeout
    // size for one cycle; the counter is reloaded again right after,
    // once the new timeout field is active.
    reg reload_pend_r;

    always @(posedge clk) begin
        if (!rstn) begin
            cnt_r         <= `IWD_RELOAD_3;
            run_r         <= 1'b0;
            reload_pend_r <= 1'b0;
        end else begin
            reload_pend_r <= 1'b0;
            if (start_r || reload_pend_r) begin
                cnt_r <= reload;
                run_r <= 1'b1;
            end else if (valid_ref) begin
                cnt_r         <= reload;
                run_r         <= 1'b1;
                reload_pend_r <= ~auto_mode_r;
            end else if (timeout) begin
                cnt_r <= reload;
                if (!auto_mode_r) begin
                    run_r <= 1'b0;
                end
            end else if (run_r && tick && !halt) begin
                cnt_r <= cnt_r - 14'h0001;
            end
        end
    end

    // ------------------------------------------------------------------
    // Timeout outputs, events and status interrupt
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        if (!rstn) begin
            wdt_reset_req         <= 1'b0;
            wdt_nmi_req           <= 1'b0;
            watchdog_maskable_irq <= 1'b0;
            count_stop_ctrl       <= 1'b0;
            evt_underflow         <= 1'b0;
            evt_refresh_err       <= 1'b0;
            sts_r                 <= 2'b00;
            irq                   <= 1'b0;
        end else begin
            wdt_reset_req         <= timeout & rsel_eff;
            wdt_nmi_req           <= timeout & ~rsel_eff & nmien_r;
            watchdog_maskable_irq <= timeout & ~rsel_eff & ~nmien_r;
            count_stop_ctrl       <= stop_eff;
            evt_underflow         <= uf;
            evt_refresh_err       <= bad_ref;
            // A new event wins over a clear in the same cycle.
            sts_r <= (sts_r & ~sts_clr) | sts_set;
            irq   <= |(sts_r & msk_r);
        end
    end

endmodule // iwd_top

// ### verification/iwd_chk.sv
`timescale 1ns/1ns
module iwd_chk (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rstn,
    // Bus answer
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    // Timeout outputs
    input wire logic        wdt_reset_req,
    input wire logic        wdt_nmi_req,
    input wire logic        watchdog_maskable_irq,
    input wire logic        evt_underflow,
    input wire logic        evt_refresh_err
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    wire logic       tmo  = evt_underflow | evt_refresh_err;
    wire logic [2:0] outs = {wdt_reset_req, wdt_nmi_req, watchdog_maskable_irq};
    sequence s_answer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    a_bus_answer: assert property ((avs_read | avs_write) && avs_waitrequest |-> ##1 s_answer)
        else $error("bus answer not one cycle");
    a_read_hold: assert property ($changed(avs_readdata) |-> !avs_waitrequest && avs_read)
        else $error("read data moved outside a read answer");
    a_uf_pulse: assert property (evt_underflow |=> !evt_underflow [*8])
        else $error("underflow event longer than one cycle");
    a_err_pulse: assert property (evt_refresh_err |=> !evt_refresh_err)
        else $error("refresh error event longer than one cycle");
    a_reset_cause: assert property (wdt_reset_req |-> tmo)
        else $error("reset request without timeout");
    a_nmi_cause: assert property (wdt_nmi_req |-> tmo)
        else $error("nmi request without timeout");
    a_mirq_cause: assert property (watchdog_maskable_irq |-> tmo)
        else $error("maskable irq without timeout");
    a_one_output: assert property (tmo |-> $onehot(outs))
        else $error("timeout did not drive exactly one output");
endmodule // iwd_chk

bind iwd_top iwd_chk u_iwd_chk (
    .clk(clk), .rstn(rstn), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .wdt_reset_req(wdt_reset_req), .wdt_nmi_req(wdt_nmi_req),
    .watchdog_maskable_irq(watchdog_maskable_irq),
    .evt_underflow(evt_underflow), .evt_refresh_err(evt_refresh_err)
);

// ### verification/iwd_partner.sv
`timescale 1ns/1ns
module iwd_partner (
    // Clock
    input  wire logic       clk,
    // Requests from the watchdog
    input  wire logic       wdt_reset_req,
    input  wire logic       wdt_nmi_req,
    input  wire logic       watchdog_maskable_irq,
    // Requests taken so far
    output logic      [7:0] rst_seen = 8'h00,
    output logic      [7:0] nmi_seen = 8'h00,
    output logic      [7:0] mirq_seen = 8'h00
);
    // The counts survive a watchdog reset, as a system reset generator would log them.
    always @(posedge clk) begin
        if (wdt_reset_req === 1'b1) rst_seen <= rst_seen + 8'h01;
        if (wdt_nmi_req === 1'b1) nmi_seen <= nmi_seen + 8'h01;
        if (watchdog_maskable_irq === 1'b1) mirq_seen <= mirq_seen + 8'h01;
    end
endmodule // iwd_partner

// ### verification/independent_window_watchdog_bench.sv
`timescale 1ns/1ns
`include "iwd_defs.vh"
module independent_window_watchdog_bench;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        dclk = 1'b0;
    logic        lp = 1'b0;
    logic [4:0]  adr = 5'h00;
    logic        rd_en = 1'b0;
    logic        wr_en = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [15:0] opt = 16'h0002;
    logic [31:0] rdat, q;
    logic        wait_rq, rst_q, nmi_q, mirq_q, cstp_q, euf, ere, irq;
    logic [7:0]  n_rst, n_nmi, n_mirq, b_rst, b_nmi, b_mirq;
    logic [13:0] rl;
    int          failures = 0;
    int          cmp_count = 0;
    int          n_uf = 0;
    int          n_re = 0;
    int          b_re;

    always #5 clk = ~clk;
    always #20 dclk = ~dclk;
    always @(posedge clk) begin
        if (euf === 1'b1) n_uf++;
        if (ere === 1'b1) n_re++;
    end

    iwd_top u_iwd_top (
        .clk(clk), .rstn(rstn), .avs_address(adr), .avs_read(rd_en), .avs_write(wr_en),
        .avs_writedata(wdat), .avs_byteenable(4'hF), .avs_readdata(rdat),
        .avs_waitrequest(wait_rq), .watchdog_dedicated_clock(dclk), .option_word_zero(opt),
        .low_power_mode(lp), .wdt_reset_req(rst_q), .wdt_nmi_req(nmi_q),
        .watchdog_maskable_irq(mirq_q), .count_stop_ctrl(cstp_q), .evt_underflow(euf),
        .evt_refresh_err(ere), .irq(irq)
    );
    iwd_partner u_iwd_partner (
        .clk(clk), .wdt_reset_req(rst_q), .wdt_nmi_req(nmi_q),
        .watchdog_maskable_irq(mirq_q), .rst_seen(n_rst), .nmi_seen(n_nmi), .mirq_seen(n_mirq)
    );

    // ------------------------------------------------------------
    // Bus tasks and checks
    // ------------------------------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        adr <= a;
        wdat <= d;
        wr_en <= w;
        rd_en <= !w;
        @(posedge clk);
        while (wait_rq !== 1'b0 && n < 50) begin
            n++;
            @(posedge clk);
        end
        q = rdat;
        rd_en <= 1'b0;
        wr_en <= 1'b0;
        chk(n < 50, 1'b1);
    endtask
    task wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task rd(input logic [4:0] a);
        bus(1'b0, a, 32'h0);
    endtask
    task refresh;
        wr(`IWD_OFS_REFRESH, 32'h0);
        wr(`IWD_OFS_REFRESH, 32'hFF);
    endtask
    task idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    task wait_uf;
        int t;
        t = n_uf;
        for (int i = 0; i < 20000 && n_uf == t; i++) @(posedge clk);
        idle(3);
        chk(n_uf - t, 32'h1);
    endtask
    task tally_and_finish;
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        #400000;
        failures++;
        tally_and_finish();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rd(`IWD_OFS_CTRL);
        chk(q, 32'h3303);
        rd(`IWD_OFS_STATUS);
        chk(q, 32'h3FFF);
        for (int a = 12; a <= 28; a += 4) begin
            rd(a[4:0]);
            chk(q, 32'h0);
        end
        rd(5'h02);
        chk(q, 32'h0);
        // A foreign byte between the two halves must break the pair.
        wr(`IWD_OFS_REFRESH, 32'h0);
        wr(`IWD_OFS_REFRESH, 32'h55);
        wr(`IWD_OFS_REFRESH, 32'hFF);
        rd(`IWD_OFS_STATUS);
        chk(q, 32'h3FFF);
        $display("test reset_and_pairing done");
        for (int k = 0; k < 4; k++) begin
            wr(`IWD_OFS_CTRL, 32'h3300 | k);
            refresh();
            rd(`IWD_OFS_STATUS);
            rl = (k == 0) ? 14'h03FF : (k == 1) ? 14'h0FFF : (k == 2) ? 14'h1FFF : 14'h3FFF;
            chk(q[14], 1'b1);
            chk(q[13:0] <= rl && q[13:0] + 32'h8 > rl, 1'b1);
        end
        $display("test timeout_table done");
        wr(`IWD_OFS_IMSK, 32'h1);
        wr(`IWD_OFS_CTRL, 32'h3300);
        refresh();
        {b_rst, b_nmi, b_mirq} = {n_rst, n_nmi, n_mirq};
        wait_uf();
        chk({n_rst, n_nmi, n_mirq}, {b_rst, b_nmi, b_mirq + 8'h01});
        rd(`IWD_OFS_STATUS);
        chk(q[14], 1'b0);
        chk(irq, 1'b1);
        wr(`IWD_OFS_ISTS, 32'h1);
        idle(2);
        chk(irq, 1'b0);
        $display("test underflow done");
        wr(`IWD_OFS_CTRL, 32'h0300);
        for (int m = 0; m < 3; m++) begin
            wr(`IWD_OFS_RSEL, (m == 0) ? 32'h80 : 32'h0);
            wr(`IWD_OFS_NMIEN, m == 1);
            {b_rst, b_nmi, b_mirq} = {n_rst, n_nmi, n_mirq};
            b_re = n_re;
            refresh();
            refresh();
            idle(3);
            chk(n_re - b_re, 32'h1);
            chk({n_rst, n_nmi, n_mirq}, {b_rst + {7'h00, m == 0}, b_nmi + {7'h00, m == 1},
                b_mirq + {7'h00, m == 2}});
            rd(`IWD_OFS_STATUS);
            chk(q[14], 1'b0);
        end
        chk(irq, 1'b0);
        rd(`IWD_OFS_ISTS);
        chk(q, 32'h2);
        $display("test refresh_error done");
        wr(`IWD_OFS_CSTP, 32'h80);
        lp <= 1'b1;
        refresh();
        idle(2);
        chk(cstp_q, 1'b1);
        rd(`IWD_OFS_STATUS);
        rl = q[13:0];
        idle(40);
        rd(`IWD_OFS_STATUS);
        chk(q[13:0], rl);
        wr(`IWD_OFS_CSTP, 32'h0);
        idle(40);
        chk(cstp_q, 1'b0);
        rd(`IWD_OFS_STATUS);
        chk(q[13:0] < rl, 1'b1);
        lp <= 1'b0;
        $display("test low_power done");
        opt <= 16'h4000;
        rstn <= 1'b0;
        idle(2);
        rstn <= 1'b1;
        b_rst = n_rst;
        rd(`IWD_OFS_CTRL);
        chk(q, 32'h3303);
        wait_uf();
        chk(n_rst, b_rst + 8'h01);
        rd(`IWD_OFS_STATUS);
        chk(q[14], 1'b1);
        $display("test auto_start done");
        tally_and_finish();
    end
endmodule // independent_window_watchdog_bench
